// ==== shared/fpsv_pkg.sv ====
package fpsv_pkg;

   ////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_MHZ        = 200;
   localparam int FLASH_HALF_MS  = 250;  // half period of flashing
   localparam int DEBOUNCE_MS    = 10;   // contact settle time
   localparam int FLASH_CYCLES   = FLASH_HALF_MS * 1000 * CLK_MHZ;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLK_MHZ;

   ////////////////////////////////////////////////////////////////////
   // lamp indices, eleven lamps
   localparam int NUM_LAMPS   = 11;
   localparam int LAMP_HLTH0  = 0;
   localparam int LAMP_ACTIVE = 3;
   localparam int LAMP_STBY   = 4;
   localparam int LAMP_EDUC   = 5;
   localparam int LAMP_RUN    = 6;
   localparam int LAMP_INHIB  = 7;
   localparam int LAMP_SYS    = 8;
   localparam int LAMP_USER0  = 9;
   localparam int NUM_SLICES  = 3;

   ////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_CMD    = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FAULT  = 8'h0C;
   localparam logic [7:0] REG_FCOUNT = 8'h10;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // field positions
   localparam int CTRL_USER0   = 0;
   localparam int CTRL_USER1   = 1;
   localparam int CTRL_DL_PERM = 2;
   localparam int CMD_FRESET   = 0;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   ////////////////////////////////////////////////////////////////////
   // status word sent by each slice
   typedef struct packed {
      logic       active;
      logic       standby;
      logic       educated;
      logic       educating;
      logic       app_running;
      logic       full_integrity;
      logic       io_locked;
      logic       cfg_mismatch;
      logic [7:0] faults;  // boot,sys,selftest,bus,io,noresp,chan,sim
   } fpsv_status_s;

   // lamp drive, one green and one red line each
   typedef struct packed {
      logic [NUM_LAMPS-1:0] green;
      logic [NUM_LAMPS-1:0] red;
   } fpsv_lamps_s;

endpackage

// ==== verilog/fpsv_debounce.sv ====
`timescale 1ns/1ps
module fpsv_debounce
   import fpsv_pkg::*;
#(
   parameter int CYCLES = DEBOUNCE_CYCLES
)(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_resetn,
   // raw contact and settled level
   input  wire logic i_raw,
   output logic      o_level
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [2:0]    sync;
   logic [CW-1:0] cnt;

   // three stage synchroniser, only stage 1 and 2 are compared
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         sync <= 3'h0;
      else
         sync <= {sync[1:0], i_raw};
   end

   // level taken once the synchronised input stays different long enough
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         cnt     <= '0;
         o_level <= 1'b0;
      end
      else if (sync[1] != sync[2] || sync[2] == o_level)
         cnt <= '0;
      else if (cnt == CW'(CYCLES - 1))
      begin
         cnt     <= '0;
         o_level <= sync[2];
      end
      else
         cnt <= cnt + 1'b1;
   end

endmodule // fpsv_debounce

// ==== verilog/fpsv_panel.sv ====
`timescale 1ns/1ps
// Overview of operation
// - drive eleven status lamps
// - vote every slice bit two of three
// - health lamps follow their own slice
// - health lamp green healthy, red failed
// - active lamp green in active mode
// - standby lamp green in standby mode
// - educated lamp steady, flashing or off
// - run lamp flashing, steady or off
// - inhibit flashes while any point locked
// - inhibit flashes on mismatched changeover attempt
// - system lamp green, flashing red, off
// - user lamps red under software control
// - failed slice switches processing to standby
// - reset clears faults, counters, requests peers
// - faults still present are recorded again
// - workstation command also resets faults
// - run position locks application memory
// - maintain position with permission allows download
module fpsv_panel
   import fpsv_pkg::*;
#(
   parameter int FLASH_HALF = FLASH_CYCLES,
   parameter int DEBOUNCE   = DEBOUNCE_CYCLES
)(
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_resetn,
   // slices
   input  wire fpsv_status_s          i_slice_status [NUM_SLICES],
   input  wire logic [NUM_SLICES-1:0] i_slice_healthy,
   // front panel controls
   input  wire logic                  i_reset_button,
   input  wire logic                  i_key_maintain,
   // panel and system outputs
   output fpsv_lamps_s                o_lamps,
   output logic                       o_changeover_req,
   output logic                       o_fault_clear,
   output logic                       o_peer_reset_req,
   output logic                       o_mem_lock,
   output logic                       o_download_en,
   // axi4-lite write
   input  wire logic [7:0]            i_awaddr,
   input  wire logic                  i_awvalid,
   output logic                       o_awready,
   input  wire logic [31:0]           i_wdata,
   input  wire logic [3:0]            i_wstrb,
   input  wire logic                  i_wvalid,
   output logic                       o_wready,
   output logic [1:0]                 o_bresp,
   output logic                       o_bvalid,
   input  wire logic                  i_bready,
   // axi4-lite read
   input  wire logic [7:0]            i_araddr,
   input  wire logic                  i_arvalid,
   output logic                       o_arready,
   output logic [31:0]                o_rdata,
   output logic [1:0]                 o_rresp,
   output logic                       o_rvalid,
   input  wire logic                  i_rready
);

   localparam int FW = $clog2(FLASH_HALF + 1);

   // majority of three
   function automatic logic maj(input logic a, input logic b,
                                input logic c);
      maj = (a & b) | (a & c) | (b & c);
   endfunction

   // register map decode
   function automatic logic known(input logic [7:0] a);
      known = (a == REG_CTRL) || (a == REG_CMD) || (a == REG_STATUS) ||
              (a == REG_FAULT) || (a == REG_FCOUNT);
   endfunction

   fpsv_status_s       voted;
   logic [15:0]        raw [NUM_SLICES];
   logic               disagree;
   logic [1:0]         settled;
   logic               btn_prev;
   logic               btn_rise;
   logic               cmd_reset;
   logic               clear_evt;
   logic [7:0]         fault_now;
   logic [7:0]         fault_rec;
   logic [7:0]         fault_prev;
   logic [7:0]         new_fault;
   logic [15:0]        fault_cnt;
   logic [2:0]         ctrl;
   logic [7:0]         aw_addr;
   logic [31:0]        w_data;
   logic [3:0]         w_strb;
   logic               do_write;
   logic [FW-1:0]      flash_cnt;
   logic               flash;
   logic               illegal;
   fpsv_lamps_s        next_lamps;

   ////////////////////////////////////////////////////////////////////
   // voting

   generate
      for (genvar s = 0; s < NUM_SLICES; s++)
      begin : g_raw
         assign raw[s] = i_slice_status[s];
      end
      for (genvar b = 0; b < 16; b++)
      begin : g_vote
         assign voted[b] = maj(raw[0][b], raw[1][b], raw[2][b]);
      end
   endgenerate

   // any slice outvoted counts as a slice error
   assign disagree = (raw[0] != raw[1]) || (raw[1] != raw[2]);

   ////////////////////////////////////////////////////////////////////
   // panel controls

   generate
      for (genvar k = 0; k < 2; k++)
      begin : g_deb
         fpsv_debounce #(.CYCLES(DEBOUNCE)) u_deb (
            .i_clk    (i_clk),
            .i_resetn (i_resetn),
            .i_raw    (k == 0 ? i_reset_button : i_key_maintain),
            .o_level  (settled[k])
         );
      end
   endgenerate

   // press edge detector
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         btn_prev <= 1'b0;
      else
         btn_prev <= settled[0];
   end

   assign btn_rise = settled[0] & ~btn_prev;

   assign cmd_reset = do_write && aw_addr == REG_CMD && w_strb[0] &&
                      w_data[CMD_FRESET];
   assign clear_evt = btn_rise | cmd_reset;

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_fault_clear    <= 1'b0;
         o_peer_reset_req <= 1'b0;
      end
      else
      begin
         o_fault_clear    <= clear_evt;
         o_peer_reset_req <= clear_evt;
      end
   end

   // key position locks or opens memory
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_mem_lock    <= 1'b1;
         o_download_en <= 1'b0;
      end
      else
      begin
         o_mem_lock    <= ~settled[1];
         o_download_en <= settled[1] & ctrl[CTRL_DL_PERM];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fault record and counter

   assign fault_now = voted.faults | {5'h00, disagree, 2'h0};
   assign new_fault = fault_now & ~fault_prev;

   // set wins over clear, faults re-recorded
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         fault_rec  <= 8'h00;
         fault_prev <= 8'h00;
      end
      else
      begin
         fault_prev <= fault_now;
         fault_rec  <= (clear_evt ? 8'h00 : fault_rec) | fault_now;
      end
   end

   // counter restarts at one while any fault is present, else zeroed
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         fault_cnt <= 16'h0000;
      else if (clear_evt)
         fault_cnt <= 16'(|fault_now);
      else if (|new_fault && fault_cnt != 16'hFFFF)
         fault_cnt <= fault_cnt + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////
   // flash divider

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         flash_cnt <= '0;
         flash     <= 1'b0;
      end
      else if (flash_cnt == FW'(FLASH_HALF - 1))
      begin
         flash_cnt <= '0;
         flash     <= ~flash;
      end
      else
         flash_cnt <= flash_cnt + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // lamp patterns

   assign illegal = voted.active & voted.standby;

   always_comb
   begin
      next_lamps = '0;
      for (int s = 0; s < NUM_SLICES; s++)
      begin
         next_lamps.green[LAMP_HLTH0 + s] = i_slice_healthy[s];
         next_lamps.red[LAMP_HLTH0 + s]   = ~i_slice_healthy[s];
      end
      next_lamps.green[LAMP_ACTIVE] = voted.active;
      next_lamps.green[LAMP_STBY] = voted.standby;
      if (voted.app_running)
         next_lamps.green[LAMP_EDUC] = voted.educated |
                                       (voted.educating & flash);
      if (voted.standby)
         next_lamps.green[LAMP_RUN] = 1'b1;
      else if (voted.app_running && voted.full_integrity)
         next_lamps.green[LAMP_RUN] = flash;
      next_lamps.green[LAMP_INHIB] = (voted.io_locked |
                                      voted.cfg_mismatch) & flash;
      if (illegal)
      begin
         next_lamps.green[LAMP_SYS] = 1'b0;
         next_lamps.red[LAMP_SYS]   = 1'b0;
      end
      else if (|fault_now)
         next_lamps.red[LAMP_SYS] = flash;
      else
         next_lamps.green[LAMP_SYS] = 1'b1;
      next_lamps.red[LAMP_USER0]     = ctrl[CTRL_USER0];
      next_lamps.red[LAMP_USER0 + 1] = ctrl[CTRL_USER1];
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         o_lamps <= '0;
      else
         o_lamps <= next_lamps;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         o_changeover_req <= 1'b0;
      else
         o_changeover_req <= ~&i_slice_healthy & voted.active;
   end

   ////////////////////////////////////////////////////////////////////
   // axi4-lite write channel

   assign do_write = ~o_awready & ~o_wready & ~o_bvalid;

   // address and data taken in either order, released after response
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         aw_addr   <= 8'h00;
         w_data    <= 32'h0000_0000;
         w_strb    <= 4'h0;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            o_awready <= 1'b0;
            aw_addr   <= i_awaddr;
         end
         else if (o_bvalid && i_bready)
            o_awready <= 1'b1;
         if (i_wvalid && o_wready)
         begin
            o_wready <= 1'b0;
            w_data   <= i_wdata;
            w_strb   <= i_wstrb;
         end
         else if (o_bvalid && i_bready)
            o_wready <= 1'b1;
      end
   end

   // write response
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_bvalid <= 1'b0;
         o_bresp  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         o_bvalid <= 1'b1;
         o_bresp  <= known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (o_bvalid && i_bready)
         o_bvalid <= 1'b0;
   end

   // control register
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         ctrl <= CTRL_RESET;
      else if (do_write && aw_addr == REG_CTRL && w_strb[0])
         ctrl <= w_data[2:0];
   end

   ////////////////////////////////////////////////////////////////////
   // axi4-lite read channel

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rresp   <= known(i_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (i_araddr)
            REG_CTRL:   o_rdata <= {29'h0, ctrl};
            REG_STATUS: o_rdata <= {11'h0, o_mem_lock, settled[1],
                                    i_slice_healthy, voted};
            REG_FAULT:  o_rdata <= {24'h0, fault_rec};
            REG_FCOUNT: o_rdata <= {16'h0, fault_cnt};
            default:    o_rdata <= 32'h0000_0000;
         endcase
      end
      else if (o_rvalid && i_rready)
      begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

endmodule // fpsv_panel

// ==== sim/fpsv_panel_checker.sv ====
`timescale 1ns/1ps
module fpsv_panel_checker
   import fpsv_pkg::*;
(
   // clock and reset
   input wire logic                  i_clk,
   input wire logic                  i_resetn,
   // slice side
   input wire fpsv_status_s          i_slice_status [NUM_SLICES],
   input wire logic [NUM_SLICES-1:0] i_slice_healthy,
   // panel outputs
   input wire fpsv_lamps_s           o_lamps,
   input wire logic                  o_changeover_req,
   input wire logic                  o_fault_clear,
   input wire logic                  o_peer_reset_req,
   input wire logic                  o_mem_lock,
   input wire logic                  o_download_en,
   // register bus
   input wire logic                  i_awvalid,
   input wire logic                  o_awready,
   input wire logic                  i_wvalid,
   input wire logic                  o_wready,
   input wire logic                  o_bvalid,
   input wire logic [7:0]            i_araddr,
   input wire logic                  i_arvalid,
   input wire logic                  o_arready,
   input wire logic [31:0]           o_rdata,
   input wire logic [1:0]            o_rresp,
   input wire logic                  o_rvalid
);
   logic [15:0] s0, s1, s2, vote;
   logic        act, stb, calm, over;

   // two of three vote and derived conditions
   assign s0 = i_slice_status[0];
   assign s1 = i_slice_status[1];
   assign s2 = i_slice_status[2];
   assign vote = (s0 & s1) | (s0 & s2) | (s1 & s2);
   assign act = vote[15];
   assign stb = vote[14];
   assign calm = i_resetn && s0 == s1 && s1 == s2 && vote[7:0] == 8'h00
                 && !(act && stb);
   assign over = i_resetn && act && !(&i_slice_healthy);

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   ////////////////////////////////////////////////////////////////////
   // bus handshakes
   sequence s_wr_both;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence s_rd_take;
      i_arvalid && o_arready;
   endsequence

   ////////////////////////////////////////////////////////////////////
   chk_health_lamp: assert property (
      $past(i_resetn) |-> o_lamps.green[2:0] == $past(i_slice_healthy)
      && o_lamps.red[2:0] == ~$past(i_slice_healthy))
      else $error("health lamp wrong");
   chk_mode_lamps: assert property (
      $past(i_resetn) |-> o_lamps.green[LAMP_ACTIVE] == $past(act)
      && o_lamps.green[LAMP_STBY] == $past(stb))
      else $error("mode lamp wrong");
   chk_sys_green: assert property (
      $past(calm) |-> o_lamps.green[LAMP_SYS] && !o_lamps.red[LAMP_SYS])
      else $error("system lamp wrong");
   chk_user_red: assert property (
      o_lamps.green[NUM_LAMPS-1:LAMP_USER0] == 2'h0)
      else $error("user lamp green");
   chk_change_over: assert property (
      $past(over) |-> o_changeover_req)
      else $error("no changeover");
   chk_clear_pair: assert property (
      o_fault_clear == o_peer_reset_req)
      else $error("peer request differs");
   chk_clear_once: assert property (
      o_fault_clear |=> !o_fault_clear)
      else $error("clear pulse too long");
   chk_lock_key: assert property (
      o_mem_lock |-> !o_download_en)
      else $error("download while locked");
   chk_wr_answer: assert property (
      s_wr_both |=> !o_awready && !o_wready ##1 o_bvalid)
      else $error("write answer late");
   chk_rd_answer: assert property (
      s_rd_take |=> o_rvalid && !o_arready)
      else $error("read answer late");
   chk_rd_unmapped: assert property (
      s_rd_take ##0 i_araddr >= 8'h14 |=> o_rresp == RESP_SLVERR
      && o_rdata == 32'h0)
      else $error("unmapped read accepted");
endmodule // fpsv_panel_checker

bind fpsv_panel fpsv_panel_checker u_chk (.*);

// ==== sim/fpsv_slices.sv ====
`timescale 1ns/1ps
module fpsv_slices
   import fpsv_pkg::*;
(
   // clock
   input  wire logic         i_clk,
   // commanded word, faulty slices, health
   input  wire fpsv_status_s i_word,
   input  wire logic [2:0]   i_bad,
   input  wire logic [2:0]   i_ok,
   // slice outputs
   output fpsv_status_s      o_status [NUM_SLICES],
   output logic [2:0]        o_healthy
);
   // each slice sends the word, a faulty one its inverse
   always_ff @(posedge i_clk)
   begin
      for (int k = 0; k < NUM_SLICES; k++)
         o_status[k] <= i_bad[k] ? fpsv_status_s'(~i_word) : i_word;
      o_healthy <= i_ok;
   end
endmodule // fpsv_slices

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench
   import fpsv_pkg::*;
;
   localparam int G = NUM_LAMPS;
   logic         clk = 1'b0, resetn = 1'b0, btn = 1'b0, key = 1'b0;
   fpsv_status_s word = '0;
   logic [2:0]   bad = 3'h0, ok = 3'h7, hl;
   fpsv_status_s st [NUM_SLICES];
   fpsv_lamps_s  lamps;
   logic [21:0]  all;
   logic         chg, fclr, mlock, dlen;
   logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]  wdata = 32'h0, rdata, d;
   logic         awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic         awready, wready, bvalid, arready, rvalid;
   logic [1:0]   bresp, rresp, r;
   int           err_count = 0, compares = 0, pulses = 0, p;

   always #2.5 clk = ~clk;
   assign all = lamps;

   // count fault clear pulses
   always @(posedge clk)
      if (fclr === 1'b1) pulses <= pulses + 1;

   fpsv_slices u_sl (.i_clk(clk), .i_word(word), .i_bad(bad), .i_ok(ok),
      .o_status(st), .o_healthy(hl));
   fpsv_panel #(.FLASH_HALF(4), .DEBOUNCE(4)) dut (
      .i_clk(clk), .i_resetn(resetn), .i_slice_status(st),
      .i_slice_healthy(hl), .i_reset_button(btn), .i_key_maintain(key),
      .o_lamps(lamps), .o_changeover_req(chg), .o_fault_clear(fclr),
      .o_peer_reset_req(), .o_mem_lock(mlock), .o_download_en(dlen),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
      .o_rvalid(rvalid), .i_rready(1'b1));

   ////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // bus write, response kept in r
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic done;
      done = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int n = 0; n < 50 && !done; n++)
      begin
         @(posedge clk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) {done, r} = {1'b1, bresp};
      end
      if (!done)
      begin
         err_count++;
         stop_test();
      end
   endtask

   // bus read into d and r
   task automatic rd(input logic [7:0] a);
      logic done;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      for (int n = 0; n < 50 && !done; n++)
      begin
         @(posedge clk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) {done, d, r} = {1'b1, rdata, rresp};
      end
      if (!done)
      begin
         err_count++;
         stop_test();
      end
   endtask

   // lamp bit high count over four flash half periods
   task automatic lamp(input logic [15:0] w, input int idx, input int exp);
      int hi;
      hi = 0;
      word <= w;
      cyc(3);
      repeat (16)
      begin
         @(posedge clk);
         hi += (all[idx] === 1'b1) ? 1 : ((all[idx] === 1'b0) ? 0 : 99);
      end
      chk(32'(hi), 32'(exp));
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_vote;
      word <= 16'h8C00;
      bad <= 3'h2;
      ok <= 3'h5;
      cyc(3);
      chk(32'(lamps.green[2:0]), 32'h5);
      chk(32'(lamps.red[2:0]), 32'h2);
      chk(32'(lamps.green[LAMP_ACTIVE]), 32'h1);
      chk(32'(lamps.green[LAMP_STBY]), 32'h0);
      chk(32'(chg), 32'h1);
      bad <= 3'h0;
      ok <= 3'h7;
      cyc(3);
      chk(32'(chg), 32'h0);
   endtask

   task automatic t_lamps;
      lamp(16'h8C00, G + LAMP_RUN, 8);
      lamp(16'hAC00, G + LAMP_EDUC, 16);
      lamp(16'h9800, G + LAMP_EDUC, 8);
      lamp(16'h4800, G + LAMP_RUN, 16);
      lamp(16'hA000, G + LAMP_EDUC, 0);
      lamp(16'hA000, G + LAMP_RUN, 0);
      lamp(16'h8E00, G + LAMP_INHIB, 8);
      lamp(16'h8D00, G + LAMP_INHIB, 8);
      lamp(16'h8C80, LAMP_SYS, 8);
      lamp(16'hCC00, G + LAMP_SYS, 0);
      lamp(16'h8C00, G + LAMP_SYS, 16);
   endtask

   task automatic t_user;
      wr(REG_CTRL, 32'h3);
      cyc(2);
      chk(32'(lamps.red[10:9]), 32'h3);
      rd(REG_CTRL);
      chk(d, 32'h3);
      wr(REG_CTRL, 32'h0);
      cyc(2);
      chk(32'(lamps.red[10:9]), 32'h0);
   endtask

   task automatic t_fault;
      for (int k = 0; k < 2; k++)
      begin
         word <= k == 0 ? 16'h8C80 : 16'h8C00;
         cyc(3);
         rd(REG_FAULT);
         chk(d, k == 0 ? 32'h84 : 32'h80);
         p = pulses;
         wr(REG_CMD, 32'h1);
         cyc(2);
         chk(32'(pulses - p), 32'h1);
         rd(REG_FAULT);
         chk(d, k == 0 ? 32'h80 : 32'h0);
         rd(REG_FCOUNT);
         chk(d, k == 0 ? 32'h1 : 32'h0);
      end
      p = pulses;
      btn <= 1'b1;
      cyc(30);
      btn <= 1'b0;
      cyc(30);
      chk(32'(pulses - p), 32'h1);
   endtask

   task automatic t_key;
      chk(32'(mlock), 32'h1);
      wr(REG_CTRL, 32'h4);
      key <= 1'b1;
      cyc(20);
      chk(32'(mlock), 32'h0);
      chk(32'(dlen), 32'h1);
      rd(REG_STATUS);
      chk(d, 32'h000F_8C00);
      wr(REG_CTRL, 32'h0);
      cyc(2);
      chk(32'(dlen), 32'h0);
      key <= 1'b0;
      cyc(20);
      chk(32'(mlock), 32'h1);
   endtask

   task automatic t_bus;
      rd(8'h40);
      chk(d, 32'h0);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(8'h40, 32'h1);
      chk(32'(r), 32'(RESP_SLVERR));
      rd(REG_CMD);
      chk(d, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      cyc(2);
      resetn <= 1'b1;
      t_vote();
      t_lamps();
      t_user();
      t_fault();
      t_key();
      t_bus();
      stop_test();
   end
endmodule // testbench
